/* File: hdl/dpm_pkg.sv */
package dpm_pkg;
  // register byte offsets
  localparam logic [7:0] DPM_CTRL_OFS = 8'h00;
  localparam logic [7:0] DPM_STAT_OFS = 8'h04;
  // control field positions
  localparam int DPM_CTRL_EN1_BIT = 6;
  localparam int DPM_CTRL_EN2_BIT = 7;
  localparam int DPM_CTRL_DIS_BIT = 0;
  localparam int DPM_CTRL_HIZ_BIT = 1;
  // status field positions
  localparam int DPM_STAT_P1_BIT = 0;
  localparam int DPM_STAT_P2_BIT = 1;
  localparam int DPM_STAT_FET1_BIT = 2;
  localparam int DPM_STAT_FET2_BIT = 3;
  localparam int DPM_STAT_GATE1_BIT = 4;
  localparam int DPM_STAT_GATE2_BIT = 5;
  localparam int DPM_STAT_SWAP_BIT = 6;
  // reset values
  localparam logic DPM_EN_RST = 1'b0;
  localparam logic DPM_DIS_RST = 1'b0;
  localparam logic DPM_HIZ_RST = 1'b0;
  // ahb encodings
  localparam logic [1:0] DPM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] DPM_HSIZE_WORD = 3'h2;
  // configuration found at power-on
  typedef enum {DPM_CFG_NONE, DPM_CFG_ONE, DPM_CFG_TWO} dpm_cfg_t;
  // changeover sequencer
  typedef enum {DPM_IDLE, DPM_BREAK, DPM_MAKE} dpm_seq_t;
endpackage

/* File: hdl/dpm_mux_ctrl.sv */
`timescale 1ns/1ps
module dpm_mux_ctrl
  import dpm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic gate1_shorted,
  input wire logic gate2_shorted,
  input wire logic input1_sense_present,
  input wire logic input1_sense_ovp,
  input wire logic input2_sense_present,
  input wire logic input2_sense_ovp,
  input wire logic converter_input_node_present,
  input wire logic input1_fault,
  input wire logic input2_fault,
  output logic path1_gate_drive,
  output logic path2_gate_drive,
  output logic converter_pause
);
  import dpm_pkg::*;

  // pin synchronisers
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end
    else
    begin
      sync_a <= {input2_fault, input1_fault, converter_input_node_present, gate2_shorted,
                 gate1_shorted, input2_sense_ovp, input2_sense_present, input1_sense_ovp};
      sync_b <= sync_a;
    end
  end
  logic in1_pres;
  logic in1_ovp;
  logic in2_pres;
  logic in2_ovp;
  logic g1_short;
  logic g2_short;
  logic node_pres;
  logic flt1;
  logic flt2;
  logic in1_pres_a;
  logic in1_pres_b;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in1_pres_a <= 1'b0;
      in1_pres_b <= 1'b0;
    end
    else
    begin
      in1_pres_a <= input1_sense_present;
      in1_pres_b <= in1_pres_a;
    end
  end
  assign in1_pres = in1_pres_b;
  assign in1_ovp = sync_b[0];
  assign in2_pres = sync_b[1];
  assign in2_ovp = sync_b[2];
  assign g1_short = sync_b[3];
  assign g2_short = sync_b[4];
  assign node_pres = sync_b[5];
  assign flt1 = sync_b[6];
  assign flt2 = sync_b[7];

  // valid input per path
  logic valid1;
  logic valid2;
  assign valid1 = in1_pres && !in1_ovp && !flt1;
  assign valid2 = in2_pres && !in2_ovp && !flt2;

  // power-on detect
  // configuration latched once the straps have passed the synchroniser
  logic [1:0] det_cnt;
  logic det_done;
  logic fet1;
  logic fet2;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      det_cnt <= 2'h0;
      det_done <= 1'b0;
      fet1 <= 1'b0;
      fet2 <= 1'b0;
    end
    else if (!det_done)
    begin
      det_cnt <= det_cnt + 2'h1;
      if (det_cnt == 2'h3)
      begin
        det_done <= 1'b1;
        fet1 <= !g1_short;
        fet2 <= !g1_short && !g2_short;
      end
    end
  end
  dpm_cfg_t cfg;
  assign cfg = fet2 ? DPM_CFG_TWO : (fet1 ? DPM_CFG_ONE : DPM_CFG_NONE);

  // bus address phase capture
  logic wr_pend;
  logic rd_sel;
  logic [7:0] addr_q;
  wire addr_ok = hsel && hready && htrans == DPM_HTRANS_NONSEQ;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_sel <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      rd_sel <= addr_ok && !hwrite;
      addr_q <= haddr[7:0];
    end
  end
  wire wr_ctrl = wr_pend && addr_q == DPM_CTRL_OFS;
  wire wr_e1 = hwdata[DPM_CTRL_EN1_BIT];
  wire wr_e2 = hwdata[DPM_CTRL_EN2_BIT];

  // control state
  logic en1;
  logic en2;
  logic dis_all;
  logic hiz;
  logic swap_flag;
  logic valid1_q;
  logic valid2_q;
  dpm_seq_t seq;
  logic tgt1;
  logic tgt2;

  // enable write decode
  // both-set ignored
  wire wr_both = wr_e1 && wr_e2;
  // zero write only with both valid
  wire zero_blocked = !wr_e1 && !wr_e2 && !(valid1 && valid2);
  wire wr_en_ok = wr_ctrl && !wr_both && !zero_blocked;

  // first valid path; dual mode acts on arrival so a host 00 stays open
  wire new1 = valid1 && (cfg == DPM_CFG_ONE || !valid1_q);
  wire new2 = valid2 && !valid2_q;
  wire auto1 = cfg != DPM_CFG_NONE && !en1 && !en2 && new1 && !dis_all;
  wire auto2 = cfg == DPM_CFG_TWO && !en1 && !en2 && !valid1 && new2 && !dis_all;
  wire fail_swap12 = cfg == DPM_CFG_TWO && en1 && !valid1 && valid2 && !dis_all;
  wire fail_swap21 = cfg == DPM_CFG_TWO && en2 && !valid2 && valid1 && !dis_all;

  // next values of the enable fields
  logic next_en1;
  logic next_en2;
  always_comb
  begin
    next_en1 = en1;
    next_en2 = en2;
    if (wr_en_ok)
    begin
      next_en1 = wr_e1;
      next_en2 = wr_e2;
    end
    if (fail_swap12)
    begin
      next_en1 = 1'b0;
      next_en2 = 1'b1;
    end
    else if (fail_swap21)
    begin
      next_en1 = 1'b1;
      next_en2 = 1'b0;
    end
    else if (auto1)
    begin
      next_en1 = 1'b1;
    end
    else if (auto2)
    begin
      next_en2 = 1'b1;
    end
    if (dis_all)
    begin
      next_en1 = 1'b0;
      next_en2 = 1'b0;
    end
    if (cfg == DPM_CFG_NONE)
      next_en1 = 1'b0;
    if (cfg != DPM_CFG_TWO)
      next_en2 = 1'b0;
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en1 <= DPM_EN_RST;
      en2 <= DPM_EN_RST;
      dis_all <= DPM_DIS_RST;
      hiz <= DPM_HIZ_RST;
      swap_flag <= 1'b0;
      valid1_q <= 1'b0;
      valid2_q <= 1'b0;
    end
    else
    begin
      en1 <= next_en1;
      en2 <= next_en2;
      valid1_q <= valid1;
      valid2_q <= valid2;
      if (det_done && cfg == DPM_CFG_NONE)
        dis_all <= 1'b1;
      else if (wr_ctrl)
        dis_all <= hwdata[DPM_CTRL_DIS_BIT];
      if (wr_ctrl)
        hiz <= hwdata[DPM_CTRL_HIZ_BIT];
      if (fail_swap12 || fail_swap21)
        swap_flag <= 1'b1;
      else if (wr_ctrl)
        swap_flag <= 1'b0;
    end
  end

  wire cond1 = fet1 && valid1 && !dis_all && !hiz;
  wire cond2 = fet2 && valid2 && !dis_all && !hiz;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seq <= DPM_IDLE;
      tgt1 <= 1'b0;
      tgt2 <= 1'b0;
    end
    else
    begin
      unique case (seq)
        DPM_IDLE:
          if ({tgt1, tgt2} != {en1, en2})
            seq <= DPM_BREAK;
        DPM_BREAK:
          if (!node_pres)
          begin
            tgt1 <= en1;
            tgt2 <= en2;
            seq <= DPM_MAKE;
          end
        DPM_MAKE:
          seq <= DPM_IDLE;
      endcase
    end
  end

  // gate drive registers
  // immediate drop
  logic next_g1;
  logic next_g2;
  wire node_ok = !node_pres || path1_gate_drive || path2_gate_drive;
  assign next_g1 = seq == DPM_IDLE && tgt1 && en1 && cond1 && node_ok;
  assign next_g2 = seq == DPM_IDLE && tgt2 && en2 && cond2 && node_ok;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      path1_gate_drive <= 1'b0;
      path2_gate_drive <= 1'b0;
    end
    else
    begin
      path1_gate_drive <= next_g1;
      path2_gate_drive <= next_g2;
    end
  end
  assign converter_pause = seq != DPM_IDLE;

  wire st1 = cfg == DPM_CFG_TWO ? 1'b1 : path1_gate_drive && cfg == DPM_CFG_ONE;
  wire st2 = cfg == DPM_CFG_TWO;

  // read mux decoded in the address phase, enables as they stand after this edge
  logic [31:0] rd_val;
  assign rd_val = haddr[7:0] == DPM_CTRL_OFS ?
    32'({next_en2, next_en1, 4'h0, hiz, dis_all}) :
    haddr[7:0] == DPM_STAT_OFS ?
    32'({swap_flag, path2_gate_drive, path1_gate_drive, fet2, fet1, st2, st1}) : 32'h0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (addr_ok && !hwrite)
      hrdata <= rd_val;
    else
      hrdata <= 32'h0;
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // assertions
  a_gate_conds: assert property (@(posedge hclk) disable iff (!hresetn)
    path1_gate_drive |-> $past(cond1 && en1)) else $error("gate1 without cond");
  a_no_both: assert property (@(posedge hclk) disable iff (!hresetn)
    !(path1_gate_drive && path2_gate_drive)) else $error("both gates on");
  a_dis_off: assert property (@(posedge hclk) disable iff (!hresetn)
    dis_all |=> !path1_gate_drive && !path2_gate_drive) else $error("disable ignored");
  a_lock_two: assert property (@(posedge hclk) disable iff (!hresetn)
    det_done && cfg != DPM_CFG_TWO |-> !en2) else $error("en2 not locked");
  a_swap_en: assert property (@(posedge hclk) disable iff (!hresetn)
    fail_swap12 && !wr_en_ok |=> en2 && !en1) else $error("swap not shown");
  a_break_make: assert property (@(posedge hclk) disable iff (!hresetn)
    seq == DPM_BREAK |-> !path1_gate_drive && !path2_gate_drive) else $error("no break");
  a_both_ign: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl && wr_both && !dis_all && cfg == DPM_CFG_TWO && !fail_swap12 && !fail_swap21
    && !auto1 && !auto2 |=> en1 == $past(en1)) else $error("both write taken");
  a_en_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !en1 |=> !path1_gate_drive) else $error("en1 off ignored");
  c_auto1: cover property (@(posedge hclk) disable iff (!hresetn) auto1);
  c_swap: cover property (@(posedge hclk) disable iff (!hresetn) fail_swap12);
  c_make: cover property (@(posedge hclk) disable iff (!hresetn) seq == DPM_MAKE);
endmodule // dpm_mux_ctrl

/* File: verif/dpm_src_model.sv */
`timescale 1ns/1ps
// input sources, fet pairs and converter node seen by the mux control
module dpm_src_model (
  input wire logic hclk,
  input wire logic [2:0] src,
  input wire logic [1:0] ovp,
  input wire logic [1:0] flt,
  input wire logic path1_gate_drive,
  input wire logic path2_gate_drive,
  output logic input1_sense_present,
  output logic input1_sense_ovp,
  output logic input2_sense_present,
  output logic input2_sense_ovp,
  output logic converter_input_node_present,
  output logic input1_fault,
  output logic input2_fault
);
  logic [3:0] lvl = 4'h0;
  // comparator levels follow the commanded sources
  assign input1_sense_present = src[0];
  assign input2_sense_present = src[1];
  assign input1_sense_ovp = ovp[0];
  assign input2_sense_ovp = ovp[1];
  assign input1_fault = flt[0];
  assign input2_fault = flt[1];
  // node decays slowly
  // node stays up for a while after the last feed goes away
  always_ff @(posedge hclk)
    if ((path1_gate_drive && src[0]) || (path2_gate_drive && src[1]) || src[2])
      lvl <= 4'hf; // bit2 is the direct source
    else if (lvl != 4'h0)
      lvl <= lvl - 4'h1;
  assign converter_input_node_present = lvl != 4'h0;
endmodule // dpm_src_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
// self-checking bench for the dual-input mux control
module tb;
  import dpm_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, vld = 1'b0;
  logic gate1_shorted = 1'b0, gate2_shorted = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, res = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, ovp = 2'h0, flt = 2'h0;
  logic [2:0] hsize = 3'h0, src = 3'h0;
  logic hreadyout, hresp, path1_gate_drive, path2_gate_drive, converter_pause;
  logic input1_sense_present, input1_sense_ovp, input2_sense_present, input2_sense_ovp;
  logic converter_input_node_present, input1_fault, input2_fault;
  logic [31:0] exp_q[$];
  int n_errors = 0, samples_checked = 0, seed = 13, i, pause_n = 0;
  always #50 hclk = ~hclk;
  dpm_mux_ctrl u_dpm_mux_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .gate1_shorted,
    .gate2_shorted, .input1_sense_present, .input1_sense_ovp, .input2_sense_present,
    .input2_sense_ovp, .converter_input_node_present, .input1_fault, .input2_fault,
    .path1_gate_drive, .path2_gate_drive, .converter_pause);
  dpm_src_model u_dpm_src_model (.hclk, .src, .ovp, .flt, .path1_gate_drive,
    .path2_gate_drive, .input1_sense_present, .input1_sense_ovp, .input2_sense_present,
    .input2_sense_ovp, .converter_input_node_present, .input1_fault, .input2_fault);
  task fail(input string s);
    n_errors++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  task complete_run;
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // compare each result with the oldest note, watch gates and pause
  always @(posedge hclk)
  begin
    if (vld && res !== exp_q.pop_front())
      fail("result differs");
    samples_checked += vld;
    if (path1_gate_drive === 1'b1 && path2_gate_drive === 1'b1)
      fail("both gates on");
    if (converter_pause === 1'b1)
      pause_n++;
    if (hresp !== 1'b0)
      fail("error response");
  end
  // hand a result and its expectation to the checker
  task note(input logic [31:0] e, input logic [31:0] r);
    exp_q.push_back(e);
    res <= r;
    vld <= 1'b1;
    @(posedge hclk);
    vld <= 1'b0;
    @(posedge hclk);
  endtask
  // one single-word transfer, held until hready is seen
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= DPM_HTRANS_NONSEQ;
    hsize <= DPM_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    note(e, hrdata & 32'hc3);
  endtask
  // wait a bounded time for the gate pair to reach a value
  task gates(input logic [1:0] e);
    repeat (60)
      if ({path2_gate_drive, path1_gate_drive} !== e) @(posedge hclk);
    note({30'h0, e}, {30'h0, path2_gate_drive, path1_gate_drive});
  endtask
  task hold(input logic [1:0] e);
    repeat (30) @(posedge hclk);
    gates(e);
  endtask
  task rst(input logic a, input logic b);
    hresetn <= 1'b0;
    gate1_shorted <= a;
    gate2_shorted <= b;
    src <= 3'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail("timeout");
    complete_run;
  end
  initial
  begin
    rst(1'b0, 1'b0);
    rd(DPM_CTRL_OFS, 32'h0);
    rd(DPM_STAT_OFS, 32'h03);
    for (i = 2; i < 8; i++) ahb(1'b1, 8'(4 * i), $random(seed));
    rd(8'h0c, 32'h0);
    rd(DPM_CTRL_OFS, 32'h0);
    src <= 3'h1;
    gates(2'h1);
    rd(DPM_CTRL_OFS, 32'h40);
    src <= 3'h3;
    hold(2'h1);
    ahb(1'b1, DPM_CTRL_OFS, 32'hc0);
    hold(2'h1);
    rd(DPM_CTRL_OFS, 32'h40);
    i = pause_n;
    ahb(1'b1, DPM_CTRL_OFS, 32'h80);
    gates(2'h2);
    note(32'h1, {31'h0, pause_n > i});
    flt <= 2'h2;
    gates(2'h1);
    rd(DPM_CTRL_OFS, 32'h40);
    rd(DPM_STAT_OFS, 32'h43);
    flt <= 2'h0;
    repeat (4) @(posedge hclk);
    ahb(1'b1, DPM_CTRL_OFS, 32'h00);
    gates(2'h0);
    ahb(1'b1, DPM_CTRL_OFS, 32'h40);
    gates(2'h1);
    ahb(1'b1, DPM_CTRL_OFS, 32'h41);
    gates(2'h0);
    ahb(1'b1, DPM_CTRL_OFS, 32'h42);
    hold(2'h0);
    ahb(1'b1, DPM_CTRL_OFS, 32'h40);
    gates(2'h1);
    rst(1'b0, 1'b1);
    src <= 3'h1;
    gates(2'h1);
    rd(DPM_CTRL_OFS, 32'h40);
    rd(DPM_STAT_OFS, 32'h01);
    ahb(1'b1, DPM_CTRL_OFS, 32'h00);
    hold(2'h1);
    ovp <= 2'h1;
    gates(2'h0);
    ovp <= 2'h0;
    gates(2'h1);
    ahb(1'b1, DPM_CTRL_OFS, 32'h01);
    gates(2'h0);
    rd(DPM_CTRL_OFS, 32'h01);
    src <= 3'h5;
    repeat (10) @(posedge hclk);
    src <= 3'h1;
    repeat (60)
      if (converter_input_node_present === 1'b1) @(posedge hclk);
    ahb(1'b1, DPM_CTRL_OFS, 32'h00);
    gates(2'h1);
    rst(1'b1, 1'b1);
    rd(DPM_CTRL_OFS, 32'h01);
    src <= 3'h3;
    ahb(1'b1, DPM_CTRL_OFS, 32'h41);
    hold(2'h0);
    rd(DPM_CTRL_OFS, 32'h01);
    rd(DPM_STAT_OFS, 32'h00);
    complete_run;
  end
endmodule // tb
